// ==== spc_checker.sv ====
// assertion checker for the self-programming control ports
`timescale 1ns/100ps
`default_nettype none
module spc_checker #(
  parameter int          WORD_BITS      = 5,
  parameter logic [15:0] HALT_SECT_BASE = 16'h0C00,
  parameter logic [15:0] BOOT_RESET     = 16'h0C00
) (
  input wire logic                       clk,
  input wire logic                       rst,
  input wire logic                       global_irq_enable,
  input wire logic                       boot_vector_fuse,
  input wire spc_pkg::spc_cpu_req_type   cpu_req,
  input wire spc_pkg::spc_cpu_rsp_type   cpu_rsp,
  input wire spc_pkg::spc_flash_cmd_type flash_cmd
);
  import spc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_vec;
    !$past(rst) && $stable(boot_vector_fuse) |-> cpu_rsp.reset_vector ==
      (boot_vector_fuse ? SPC_APP_RESET : BOOT_RESET);
  endproperty
  a_vec: assert property (p_vec)
    else $error("reset vector does not follow the boot fuse");
  property p_irq;
    cpu_rsp.ready_irq |-> global_irq_enable && !flash_cmd.start;
  endproperty
  a_irq: assert property (p_irq)
    else $error("ready irq raised while gated off");
  property p_busy;
    flash_cmd.start && flash_cmd.page_word_addr < HALT_SECT_BASE |->
      ##[0:1] cpu_rsp.section_busy_flag && !cpu_rsp.cpu_halt;
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy flag missing on concurrent-section op");
  property p_halt;
    flash_cmd.start && flash_cmd.page_word_addr >= HALT_SECT_BASE |->
      ##[0:1] cpu_rsp.cpu_halt;
  endproperty
  a_halt: assert property (p_halt)
    else $error("cpu not halted on halting-section op");
  // halt must hold for at least eight cycles, not a single stall cycle
  property p_hold;
    $rose(cpu_rsp.cpu_halt) |-> cpu_rsp.cpu_halt[*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("cpu halt dropped early");
  property p_load;
    cpu_rsp.load_valid |-> $past(cpu_req.load_valid);
  endproperty
  a_load: assert property (p_load)
    else $error("load answer without load instruction");
  property p_clear;
    $fell(cpu_rsp.section_busy_flag) |->
      $past(cpu_req.store_valid) || $past(cpu_req.store_valid, 2);
  endproperty
  a_clear: assert property (p_clear)
    else $error("busy flag cleared without a store");
  property p_latch;
    flash_cmd.start |-> flash_cmd.page_word_addr[WORD_BITS-1:0] == '0
      ##1 $stable(flash_cmd.page_word_addr)[*3];
  endproperty
  a_latch: assert property (p_latch)
    else $error("page address not latched");
endmodule
bind spc_self_program spc_checker #(
  .WORD_BITS(WORD_BITS), .HALT_SECT_BASE(HALT_SECT_BASE),
  .BOOT_RESET(BOOT_RESET)
) chk (.clk(clk), .rst(rst), .global_irq_enable(global_irq_enable),
  .boot_vector_fuse(boot_vector_fuse), .cpu_req(cpu_req),
  .cpu_rsp(cpu_rsp), .flash_cmd(flash_cmd));
`default_nettype wire

// ==== spc_cpu_model.sv ====
// cpu core model issuing store and load program instructions
`timescale 1ns/100ps
`default_nettype none
module spc_cpu_model (
  input  wire logic                     clk,
  output var spc_pkg::spc_cpu_req_type  cpu_req,
  input  wire spc_pkg::spc_cpu_rsp_type cpu_rsp
);
  import spc_pkg::*;
  initial cpu_req = '0;
  // one-cycle instruction pulse; released fields show inverted junk
  task automatic store(input logic [15:0] p, input logic [15:0] w);
    cpu_req.store_valid <= 1'b1;
    cpu_req.pointer <= p;
    cpu_req.data_word <= w;
    @(posedge clk);
    cpu_req.store_valid <= 1'b0;
    cpu_req.pointer <= ~p;
    cpu_req.data_word <= ~w;
  endtask
  task automatic load(input logic [15:0] p, output logic [8:0] v);
    cpu_req.load_valid <= 1'b1;
    cpu_req.pointer <= p;
    @(posedge clk);
    cpu_req.load_valid <= 1'b0;
    cpu_req.pointer <= ~p;
    @(negedge clk);
    v = {cpu_rsp.load_valid, cpu_rsp.load_data};
  endtask
endmodule
`default_nettype wire

// ==== spc_page_buffer.sv ====
// temporary page buffer holding one flash page of words
`timescale 1ns/100ps
`default_nettype none
module spc_page_buffer #(
  parameter int WORD_BITS = 5
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 wr_en,
  input  wire logic [WORD_BITS-1:0] wr_addr,
  input  wire logic [15:0]          wr_data,
  input  wire logic                 clear,
  input  wire logic [WORD_BITS-1:0] rd_addr,
  output logic      [15:0]          rd_data
);
  import spc_pkg::*;
  localparam int DEPTH = 1 << WORD_BITS;
  logic [15:0]     mem [DEPTH];
  logic [DEPTH-1:0] filled;

  // erased cells read as all ones, like erased flash
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filled <= '0;
    end else if (clear) begin
      filled <= '0;
    end else if (wr_en) begin
      filled[wr_addr] <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 16'hFFFF;
    end else begin
      rd_data <= filled[rd_addr] ? mem[rd_addr] : 16'hFFFF;
    end
  end
endmodule
`default_nettype wire

// ==== spc_pkg.sv ====
// package of constants and carrier types for the self-programming control
package spc_pkg;
  localparam logic [31:0] SPC_CSR_ADDR      = 32'h0000_0000;
  localparam logic [31:0] SPC_LOCK_ADDR     = 32'h0000_0004;
  localparam logic [31:0] SPC_FUSE_ADDR     = 32'h0000_0008;
  localparam logic [31:0] SPC_STATUS_ADDR   = 32'h0000_000C;
  localparam logic [7:0]  SPC_CSR_RESET     = 8'h00;
  localparam logic [7:0]  SPC_LOCK_RESET    = 8'hFF;
  localparam int          SPC_BIT_IRQ_EN    = 7;
  localparam int          SPC_BIT_BUSY      = 6;
  localparam int          SPC_BIT_REENABLE  = 4;
  localparam int          SPC_BIT_LOCK_SET  = 3;
  localparam int          SPC_BIT_PG_WRITE  = 2;
  localparam int          SPC_BIT_PG_ERASE  = 1;
  localparam int          SPC_BIT_ENABLE    = 0;
  localparam logic [4:0]  SPC_CMD_REENABLE  = 5'h11;
  localparam logic [4:0]  SPC_CMD_LOCK_SET  = 5'h09;
  localparam logic [4:0]  SPC_CMD_PG_WRITE  = 5'h05;
  localparam logic [4:0]  SPC_CMD_PG_ERASE  = 5'h03;
  localparam logic [4:0]  SPC_CMD_BUF_LOAD  = 5'h01;
  localparam logic [2:0]  SPC_STORE_WINDOW  = 3'h4;
  localparam logic [2:0]  SPC_LOAD_WINDOW   = 3'h3;
  localparam logic [15:0] SPC_APP_RESET     = 16'h0000;
  localparam int          SPC_PROG_TIME_NS  = 4000;
  localparam int          SPC_CLK_NS        = 10;
  localparam int          SPC_PROG_CYCLES   =
    (SPC_PROG_TIME_NS + SPC_CLK_NS - 1) / SPC_CLK_NS;
  localparam logic [1:0]  SPC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  SPC_RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    SPC_IDLE    = 2'b00,
    SPC_ARMED   = 2'b01,
    SPC_PROGRAM = 2'b10
  } spc_phase_type;

  typedef struct packed {
    logic        store_valid;
    logic        load_valid;
    logic [15:0] pointer;
    logic [15:0] data_word;
  } spc_cpu_req_type;

  typedef struct packed {
    logic        cpu_halt;
    logic        section_busy_flag;
    logic        ready_irq;
    logic        load_valid;
    logic [7:0]  load_data;
    logic [15:0] reset_vector;
  } spc_cpu_rsp_type;

  typedef struct packed {
    logic        start;
    logic        erase;
    logic [15:0] page_word_addr;
  } spc_flash_cmd_type;
endpackage

// ==== spc_self_program.sv ====
// self-programming control: csr, command arming, page ops, lock readback
// Overview of operation
// - boot fuse picks application or loader reset
// - fuses are read-only to the cpu
// - ready irq while enable bit is zero
// - busy flag set on concurrent-section page op
// - busy clears on reenable or buffer load
// - reenable refused while erase or write runs
// - reenable during loading discards buffered data
// - lock set programs lock bits from r0
// - load within three cycles reads lock/fuse
// - page write stores buffer to pointer page
// - page erase clears page at pointer page
// - halting-section page op stalls the cpu
// - enable arms store for four cycles
// - enable alone loads r1:r0 into buffer
// - only five command patterns take effect
// - bit five reads as zero
// - split pointer into word and page, latched
// - loads pick lock or fuse by byte pointer bit zero only
// - lock bits only programmed, never erased here
`timescale 1ns/100ps
`default_nettype none
module spc_self_program #(
  parameter int          WORD_BITS      = 5,
  parameter logic [15:0] HALT_SECT_BASE = 16'h0C00,
  parameter logic [15:0] BOOT_RESET     = 16'h0C00,
  parameter int          PROG_CYCLES    = spc_pkg::SPC_PROG_CYCLES
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [31:0]                s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic      [1:0]                 s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [31:0]                s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic      [31:0]                s_axi_rdata,
  output logic      [1:0]                 s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       global_irq_enable,
  input  wire logic                       boot_vector_fuse,
  input  wire logic [7:0]                 fuse_low,
  input  wire spc_pkg::spc_cpu_req_type   cpu_req,
  output spc_pkg::spc_cpu_rsp_type        cpu_rsp,
  output spc_pkg::spc_flash_cmd_type      flash_cmd,
  output logic      [15:0]                flash_wdata
);
  import spc_pkg::*;
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  typedef struct packed {
    spc_phase_type    phase;
    logic [7:0]       csr;
    logic [2:0]       window;
    logic [CNT_W-1:0] prog_cnt;
    logic             halting;
    logic             loading;
    logic [7:0]       lock_bits;
    logic [15:0]      latched_addr;
    logic             aw_held;
    logic             w_held;
    logic [31:0]      aw_addr;
    logic [31:0]      w_data;
    logic             w_strb0;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             ld_valid;
    logic [7:0]       ld_data;
    logic [15:0]      rst_vec;
    logic             cmd_start;
    logic             cmd_erase;
  } spc_state_type;

  spc_state_type state;
  spc_state_type next_state;
  logic          buf_wr;
  logic          buf_clear;
  logic [15:0]   buf_rd;
  logic [4:0]    cmd;
  logic          csr_write;

  spc_page_buffer #(
    .WORD_BITS(WORD_BITS)
  ) u_buffer (
    .clk    (clk),
    .rst    (rst),
    .wr_en  (buf_wr),
    .wr_addr(cpu_req.pointer[WORD_BITS:1]),
    .wr_data(cpu_req.data_word),
    .clear  (buf_clear),
    .rd_addr(state.latched_addr[WORD_BITS-1:0]),
    .rd_data(buf_rd)
  );

  always_comb begin
    next_state = state;
    buf_wr     = 1'b0;
    buf_clear  = 1'b0;
    next_state.cmd_start = 1'b0;
    next_state.ld_valid  = 1'b0;
    // vector follows the fuse continuously; fuse is an input only
    next_state.rst_vec = boot_vector_fuse ? SPC_APP_RESET
                                          : BOOT_RESET;
    // axi write side: address and data taken in either order
    if (s_axi_awvalid && !state.aw_held) begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_held) begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      // strobe kept with the data: the master may drop it once w is taken
      next_state.w_strb0 = s_axi_wstrb[0];
    end
    csr_write = 1'b0;
    cmd       = state.w_data[4:0];
    if (state.aw_held && state.w_held && !state.bvalid) begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = SPC_RESP_OKAY;
      if (state.aw_addr == SPC_CSR_ADDR) begin
        if (state.w_data[0] == 1'b1 || state.w_data[0] == 1'b0) begin
          csr_write = 1'b1;
        end
      end else if (state.aw_addr != SPC_LOCK_ADDR &&
                   state.aw_addr != SPC_FUSE_ADDR &&
                   state.aw_addr != SPC_STATUS_ADDR) begin
        next_state.bresp = SPC_RESP_SLVERR;
      end
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid = 1'b0;
    end
    if (csr_write && state.w_strb0) begin
      next_state.csr[SPC_BIT_IRQ_EN] = state.w_data[SPC_BIT_IRQ_EN];
      // command bits only take while idle; busy op keeps enable high
      if (state.phase == SPC_IDLE) begin
        unique case (cmd)
          SPC_CMD_REENABLE, SPC_CMD_LOCK_SET, SPC_CMD_PG_WRITE,
          SPC_CMD_PG_ERASE, SPC_CMD_BUF_LOAD: begin
            next_state.csr[4:0] = cmd;
            next_state.phase    = SPC_ARMED;
            next_state.window   = SPC_STORE_WINDOW;
            if (cmd == SPC_CMD_REENABLE && state.loading) begin
              buf_clear          = 1'b1;
              next_state.loading = 1'b0;
            end
          end
          default: begin
          end
        endcase
      end
    end
    // armed window countdown
    if (state.phase == SPC_ARMED) begin
      if (state.window == 3'h1) begin
        next_state.csr[4:0] = 5'h00;
        next_state.phase    = SPC_IDLE;
      end else begin
        next_state.window = state.window - 3'h1;
      end
      if (cpu_req.load_valid && state.csr[4:0] == SPC_CMD_LOCK_SET &&
          state.window > (SPC_STORE_WINDOW - SPC_LOAD_WINDOW)) begin
        next_state.ld_valid = 1'b1;
        next_state.ld_data  = cpu_req.pointer[0] ? state.lock_bits
                                                 : fuse_low;
        next_state.csr[4:0] = 5'h00;
        next_state.phase    = SPC_IDLE;
      end else if (cpu_req.store_valid) begin
        next_state.csr[4:0] = 5'h00;
        next_state.phase    = SPC_IDLE;
        unique case (state.csr[4:0])
          SPC_CMD_BUF_LOAD: begin
            buf_wr                             = 1'b1;
            next_state.loading                 = 1'b1;
            next_state.csr[SPC_BIT_BUSY]       = 1'b0;
          end
          SPC_CMD_REENABLE: begin
            next_state.csr[SPC_BIT_BUSY] = 1'b0;
            buf_clear                    = 1'b1;
            next_state.loading           = 1'b0;
          end
          SPC_CMD_LOCK_SET: begin
            // r0 bits can only program (clear) lock bits
            next_state.lock_bits = state.lock_bits &
                                   cpu_req.data_word[7:0];
          end
          SPC_CMD_PG_WRITE, SPC_CMD_PG_ERASE: begin
            next_state.phase    = SPC_PROGRAM;
            next_state.csr[4:0] = state.csr[4:0];
            next_state.prog_cnt = CNT_W'(PROG_CYCLES);
            next_state.latched_addr = {1'b0, cpu_req.pointer[15:WORD_BITS+1],
                                       WORD_BITS'(0)};
            next_state.cmd_start = 1'b1;
            next_state.cmd_erase = state.csr[SPC_BIT_PG_ERASE];
            if ({1'b0, cpu_req.pointer[15:1]} >= HALT_SECT_BASE) begin
              next_state.halting = 1'b1;
            end else begin
              next_state.csr[SPC_BIT_BUSY] = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (state.phase == SPC_PROGRAM) begin
      if (state.prog_cnt == '0) begin
        next_state.phase    = SPC_IDLE;
        next_state.csr[4:0] = 5'h00;
        next_state.halting  = 1'b0;
        if (state.csr[SPC_BIT_PG_WRITE]) begin
          buf_clear          = 1'b1; // buffer auto-erases after write
          next_state.loading = 1'b0;
        end
      end else begin
        next_state.prog_cnt = state.prog_cnt - CNT_W'(1);
      end
    end
    // axi read side
    if (s_axi_arvalid && !state.rvalid) begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = SPC_RESP_OKAY;
      unique case (s_axi_araddr)
        SPC_CSR_ADDR:    next_state.rdata = {24'h0, state.csr[7:6], 1'b0,
                                             state.csr[4:0]};
        SPC_LOCK_ADDR:   next_state.rdata = {24'h0, state.lock_bits};
        SPC_FUSE_ADDR:   next_state.rdata = {24'h0, fuse_low};
        SPC_STATUS_ADDR: next_state.rdata = {29'h0, state.loading,
                                             state.halting,
                                             state.phase == SPC_PROGRAM};
        default: begin
          next_state.rdata = 32'h0;
          next_state.rresp = SPC_RESP_SLVERR;
        end
      endcase
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state       <= '0;
      state.phase <= SPC_IDLE;
      state.csr   <= SPC_CSR_RESET;
      state.lock_bits <= SPC_LOCK_RESET;
      state.rst_vec   <= SPC_APP_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign s_axi_awready = !state.aw_held;
  assign s_axi_wready  = !state.w_held;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

  always_comb begin
    cpu_rsp.cpu_halt          = state.halting;
    cpu_rsp.section_busy_flag = state.csr[SPC_BIT_BUSY];
    cpu_rsp.ready_irq         = state.csr[SPC_BIT_IRQ_EN] &&
                                global_irq_enable &&
                                !state.csr[SPC_BIT_ENABLE];
    cpu_rsp.load_valid        = state.ld_valid;
    cpu_rsp.load_data         = state.ld_data;
    cpu_rsp.reset_vector      = state.rst_vec;
    flash_cmd.start           = state.cmd_start;
    flash_cmd.erase           = state.cmd_erase;
    flash_cmd.page_word_addr  = state.latched_addr;
  end
  // page write data is the buffer word at the latched word address, word 0 of the page
  assign flash_wdata = buf_rd;
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking testbench for the self-programming control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import spc_pkg::*;
  logic                clk = 0;
  logic                rst = 1;
  logic                fuse = 1;
  logic                gie = 0;
  logic [31:0]         awaddr = 0, wdata = 0, araddr = 0, rdata, rd_data;
  logic                awvalid = 0, wvalid = 0, bready = 0;
  logic                arvalid = 0, rready = 0;
  logic                awready, wready, bvalid, arready, rvalid, start_d;
  logic [1:0]          bresp, rresp, rd_resp, wr_resp;
  logic [3:0]          wstrb = 4'hF;
  logic [8:0]          v;
  logic [15:0]         wdat, last_wd;
  spc_cpu_req_type     cpu_req;
  spc_cpu_rsp_type     cpu_rsp;
  spc_flash_cmd_type   flash_cmd, last_cmd;
  int                  fail_count = 0, n_checks = 0, n_start = 0;
  always #5 clk = ~clk;
  spc_self_program #(.WORD_BITS(5), .HALT_SECT_BASE(16'h0C00),
    .BOOT_RESET(16'h0C00), .PROG_CYCLES(16)) uut (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .global_irq_enable(gie),
    .boot_vector_fuse(fuse), .fuse_low(8'h5A), .cpu_req(cpu_req),
    .cpu_rsp(cpu_rsp), .flash_cmd(flash_cmd), .flash_wdata(wdat));
  spc_cpu_model cpu (.clk(clk), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));
  always @(posedge clk) begin
    start_d <= flash_cmd.start;
    if (flash_cmd.start) begin
      n_start <= n_start + 1;
      last_cmd <= flash_cmd;
    end
    if (start_d) last_wd <= wdat;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ready is looked at before the edge, so the edge itself decides
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bit at, wt, bt;
    @(posedge clk);
    awaddr <= a; wdata <= {24'h0, d};
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (int n = 0; n < 100 && !bt; n++) begin
      @(negedge clk);
      at = awvalid && awready; wt = wvalid && wready; bt = bvalid;
      wr_resp = bresp;
      @(posedge clk);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk(32'(bt), 1);
  endtask
  task automatic rd(input logic [31:0] a);
    bit at, rt;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (int n = 0; n < 100 && !rt; n++) begin
      @(negedge clk);
      at = arvalid && arready; rt = rvalid;
      rd_data = rdata; rd_resp = rresp;
      @(posedge clk);
      if (at) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk(32'(rt), 1);
  endtask
  task automatic rchk(input logic [31:0] a, input logic [7:0] e);
    rd(a);
    chk(rd_data, {24'h0, e});
  endtask
  task automatic cmd(input logic [4:0] c);
    wr(SPC_CSR_ADDR, {3'h0, c});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 40; i++) begin
      rd(SPC_CSR_ADDR);
      if (rd_data[0] === 1'b0) break;
    end
    chk(32'(rd_data[0]), 0);
  endtask
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk(SPC_CSR_ADDR, SPC_CSR_RESET);
    chk(32'(rd_resp), 32'(SPC_RESP_OKAY));
    rchk(SPC_LOCK_ADDR, SPC_LOCK_RESET);
    chk(32'(cpu_rsp.reset_vector), 32'(SPC_APP_RESET));
    wr(SPC_FUSE_ADDR, 8'h00);
    chk(32'(wr_resp), 32'(SPC_RESP_OKAY));
    rchk(SPC_FUSE_ADDR, 8'h5A);
    rd(32'h40);
    chk(32'(rd_resp), 32'(SPC_RESP_SLVERR));
    wr(32'h40, 8'h00);
    chk(32'(wr_resp), 32'(SPC_RESP_SLVERR));
    wr(SPC_CSR_ADDR, 8'h20);
    rchk(SPC_CSR_ADDR, 8'h00);
    wr(SPC_CSR_ADDR, 8'h07);
    rchk(SPC_CSR_ADDR, 8'h00);
    wstrb <= 4'hE;
    wr(SPC_CSR_ADDR, 8'h81);
    wstrb <= 4'hF;
    rchk(SPC_CSR_ADDR, 8'h00);
    cmd(SPC_CMD_BUF_LOAD);
    cpu.store(16'h0401, 16'h1234);
    rchk(SPC_CSR_ADDR, 8'h00);
    rchk(SPC_STATUS_ADDR, 8'h04);
    cmd(SPC_CMD_PG_ERASE);
    repeat (5) @(posedge clk);
    cpu.store(16'h0400, 16'h0000);
    rchk(SPC_CSR_ADDR, 8'h00);
    cmd(SPC_CMD_PG_WRITE);
    cpu.store(16'h0400, 16'hFFFF);
    rchk(SPC_CSR_ADDR, 8'h45);
    chk(n_start, 1);
    chk(32'(last_cmd.page_word_addr), 32'h0200);
    chk(32'(last_cmd.erase), 0);
    chk(32'(last_wd), 32'h1234);
    cmd(SPC_CMD_REENABLE);
    cpu.store(16'h0000, 16'h0000);
    wait_idle();
    rchk(SPC_CSR_ADDR, 8'h40);
    gie <= 1'b1;
    wr(SPC_CSR_ADDR, 8'h80);
    @(negedge clk);
    chk(32'(cpu_rsp.ready_irq), 1);
    @(posedge clk);
    gie <= 1'b0;
    @(negedge clk);
    chk(32'(cpu_rsp.ready_irq), 0);
    cmd(SPC_CMD_REENABLE);
    cpu.store(16'h0000, 16'h0000);
    rchk(SPC_CSR_ADDR, 8'h00);
    cmd(SPC_CMD_PG_ERASE);
    cpu.store(16'h1800, 16'h0000);
    repeat (2) @(negedge clk);
    chk(32'(cpu_rsp.cpu_halt), 1);
    chk(32'(last_cmd.erase), 1);
    chk(32'(last_cmd.page_word_addr), 32'h0C00);
    rchk(SPC_STATUS_ADDR, 8'h03);
    wait_idle();
    cmd(SPC_CMD_LOCK_SET);
    cpu.store(16'hFFFF, 16'hAAF3);
    wait_idle();
    rchk(SPC_LOCK_ADDR, 8'hF3);
    rchk(SPC_CSR_ADDR, 8'h00);
    cmd(SPC_CMD_LOCK_SET);
    cpu.store(16'h0001, 16'h00FF);
    rchk(SPC_LOCK_ADDR, 8'hF3);
    cmd(SPC_CMD_LOCK_SET);
    cpu.load(16'h0001, v);
    chk(32'(v), 32'h1F3);
    cmd(SPC_CMD_LOCK_SET);
    cpu.load(16'h0000, v);
    chk(32'(v), 32'h15A);
    rchk(SPC_CSR_ADDR, 8'h00);
    cmd(SPC_CMD_BUF_LOAD);
    cpu.store(16'h0402, 16'h5555);
    rchk(SPC_STATUS_ADDR, 8'h04);
    cmd(SPC_CMD_REENABLE);
    rchk(SPC_STATUS_ADDR, 8'h00);
    fuse <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(cpu_rsp.reset_vector), 32'h0C00);
    stop_test();
  end
endmodule
`default_nettype wire
